// ---- wdwk_pkg.sv ----
// constants, types and register map of the watchdog and wake-up controller
// assumes a 32-bit AHB-Lite bus and one system clock
package wdwk_pkg;

  // register byte offsets (haddr[7:0])
  localparam logic [7:0] OFF_WDT_CTRL  = 8'h00;
  localparam logic [7:0] OFF_PA_WAKE   = 8'h04;
  localparam logic [7:0] OFF_STATUS    = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h0c;
  localparam logic [7:0] OFF_IRQ_CLR   = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN    = 8'h14;
  localparam logic [7:0] OFF_WDT_CNT   = 8'h18;
  localparam logic [7:0] OFF_CONFIG    = 8'h1c;

  // reset values
  localparam logic [7:0] WDT_CTRL_RST  = 8'h7a;
  localparam logic [7:0] PA_WAKE_RST   = 8'h00;
  localparam logic [5:0] CONFIG_RST    = 6'h07;
  localparam logic [7:0] PA_IDLE_LVL   = 8'hff;

  // watchdog_control fields
  localparam int IDLE_KEEP_BIT = 7;
  localparam int PSEL_LSB      = 4;
  localparam int SOFT_LSB      = 0;
  localparam logic [3:0] SOFT_DISABLE = 4'ha;

  // config register fields
  localparam int CFG_WDT_EN    = 0;
  localparam int CFG_SRC_SUB   = 1;
  localparam int CFG_SUB_LXT   = 2;
  localparam int CFG_TWO_CLR   = 3;
  localparam int CFG_FAST_ST   = 4;
  localparam int CFG_SYS_HXT   = 5;

  // interrupt status bits
  localparam int IRQ_W         = 3;
  localparam int IRQ_TIMEOUT   = 0;
  localparam int IRQ_WAKE      = 1;
  localparam int IRQ_HS_READY  = 2;

  // timing, in cycles of the oscillator concerned
  localparam int WDT_BASE_LOG2 = 8;
  localparam int CNT_W         = 15;
  localparam int SYS_DIV       = 4;
  localparam int HS_SST_CYC    = 16;
  localparam int LXT_SST_CYC   = 1024;
  localparam int SST_W         = 11;

  // AHB encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    MODE_RUN    = 3'b000,
    MODE_IDLE0  = 3'b001,
    MODE_IDLE_FULL_CLOCK_MODE  = 3'b010,
    MODE_DEEP_STOP_MODE = 3'b011,
    MODE_STOP_WITH_SUBCLOCK_MODE = 3'b100,
    MODE_START  = 3'b101
  } wdwk_mode_t;

  typedef enum logic [1:0] {
    CLR_NONE   = 2'b00,
    CLR_FIRST  = 2'b01,
    CLR_SECOND = 2'b10
  } wdwk_clr_t;

  // instruction strobes from the core, one-cycle pulses
  typedef struct packed {
    logic halt;
    logic idle_en;
    logic clr;
    logic clr1;
    logic clr2;
    logic ext_rst;
  } wdwk_cpu_t;

  // wake-up and reset requests to the core, one-cycle pulses
  typedef struct packed {
    logic full_reset;
    logic pcsp_reset;
    logic sys_reset;
    logic resume;
    logic int_take;
  } wdwk_wake_t;

endpackage

// ---- wdwk_tb.sv ----
// self-checking bench for the watchdog and wake-up controller
// assumes wdwk_pkg and wdwk_top are compiled first; one 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wdwk_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        stack_full, lxt_tick, internal_low_rc_osc_tick, tick_on, sysclk_run, sysclk_low, irq, dphase;
  logic [31:0] haddr, hwdata, hrdata, v, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  intr_req, intr_en, porta_in;
  wdwk_cpu_t   cpu;
  wdwk_wake_t  wake;
  wdwk_mode_t  mode;
  int          err_count, checked, i, seed;
  logic [31:0] rd_q[$], mk_q[$];
  logic [4:0]  wk_q[$];

  assign hready = hreadyout;

  wdwk_top #(.HS_SST(4), .LXT_SST(8)) wdwk_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cpu(cpu), .intr_req(intr_req),
    .intr_en(intr_en), .stack_full(stack_full), .porta_in(porta_in), .lxt_tick(lxt_tick),
    .internal_low_rc_osc_tick(internal_low_rc_osc_tick), .wake(wake), .mode(mode), .sysclk_run(sysclk_run),
    .sysclk_low(sysclk_low), .irq(irq));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // crystal ticks every other cycle while enabled, low rc one cycle behind
  always @(posedge hclk) begin
    lxt_tick <= tick_on & ~lxt_tick;
    internal_low_rc_osc_tick <= lxt_tick;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (rd_q.size() != 0 || wk_q.size() != 0) err_count++;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic fail;
    err_count++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    stop_test();
  endtask

  // monitor: read data and wake pulses against the oldest note
  always @(posedge hclk) begin
    if (dphase === 1'b1 && hready === 1'b1) chk(hrdata & mk_q.pop_front(), rd_q.pop_front());
    if (dphase === 1'b1 && hready === 1'b1) chk(hresp, HRESP_OKAY);
    if (hresetn === 1'b1 && wake !== 5'h00) chk(wake, (wk_q.size() > 0) ? wk_q.pop_front() : 5'h00);
    if (hready === 1'b1) dphase <= hsel & htrans[1] & ~hwrite;
  end

  task automatic wt;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (n >= 20) fail();
  endtask

  task automatic bus(input logic w, input logic [2:0] s, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    if (!w) rd_q.push_back(d);
    if (!w) mk_q.push_back(m);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    hsize <= s;
    wt();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    wt();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, HSIZE_WORD, a, d, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    bus(1'b0, HSIZE_WORD, a, d, m);
  endtask

  task automatic cmd(input logic [5:0] c);
    @(posedge hclk);
    cpu <= c;
    @(posedge hclk);
    cpu <= 6'h00;
    #1;
  endtask

  task automatic wait_q(input int n);
    for (int k = 0; k < n && wk_q.size() > 0; k++) @(posedge hclk);
    if (wk_q.size() > 0) fail();
    #1;
  endtask

  task automatic settle;
    repeat (2) @(posedge hclk);
    #1;
  endtask

  initial begin
    seed = 32'h80e8_ec35;
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata, dphase} = '0;
    hsize = HSIZE_WORD;
    {cpu, intr_req, intr_en, stack_full, tick_on, lxt_tick, internal_low_rc_osc_tick} = '0;
    porta_in = PA_IDLE_LVL;
    err_count = 0;
    checked = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 60 && mode !== MODE_RUN; i++) @(posedge hclk);
    if (mode !== MODE_RUN) fail();
    rd(OFF_WDT_CTRL, 32'h7a, 32'hffff_ffff);
    rd(OFF_PA_WAKE, 32'h0, 32'hffff_ffff);
    rd(OFF_CONFIG, 32'h07, 32'hffff_ffff);
    rd(OFF_IRQ_EN, 32'h0, 32'hffff_ffff);
    rd(OFF_IRQ_CLR, 32'h0, 32'hffff_ffff);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0, 32'hffff_ffff);
    wr(OFF_STATUS, 32'hffff_ffff);
    rd(OFF_STATUS, 32'h0, 32'h3);
    v = $random(seed);
    r = $random(seed);
    wr(OFF_WDT_CTRL, v);
    rd(OFF_WDT_CTRL, {24'h00_0000, v[7:0]}, 32'hffff_ffff);
    wr(OFF_WDT_CTRL, 32'h85);
    // a byte-size write is ignored
    bus(1'b1, 3'h0, OFF_WDT_CTRL, 32'h0, 32'h0);
    rd(OFF_WDT_CTRL, 32'h85, 32'hffff_ffff);
    wr(OFF_PA_WAKE, 32'h01);
    // idle with clock kept, disabled pin then enabled pin
    cmd(6'h30);
    chk(mode, MODE_IDLE_FULL_CLOCK_MODE);
    chk(sysclk_run, 1'b1);
    @(posedge hclk) porta_in <= {r[7:2], 2'b01};
    settle();
    chk(mode, MODE_IDLE_FULL_CLOCK_MODE);
    @(posedge hclk) porta_in <= {r[7:2], 2'b00};
    wk_q.push_back(5'h02);
    wait_q(5);
    chk(mode, MODE_RUN);
    rd(OFF_STATUS, 32'h1, 32'h3);
    // interrupt wake: pending one ignored, fresh one serviced or resumed
    @(posedge hclk) porta_in <= {r[7:2], 2'b11};
    intr_en <= {r[7:2], 2'b10};
    intr_req <= 8'h01;
    stack_full <= r[0];
    cmd(6'h30);
    settle();
    chk(mode, MODE_IDLE_FULL_CLOCK_MODE);
    wk_q.push_back(r[0] ? 5'h02 : 5'h01);
    @(posedge hclk) intr_req <= 8'h03;
    wait_q(5);
    @(posedge hclk) intr_req <= 8'h00;
    stack_full <= 1'b1;
    cmd(6'h30);
    wk_q.push_back(5'h02);
    @(posedge hclk) intr_req <= 8'h02;
    wait_q(5);
    @(posedge hclk) intr_req <= 8'h00;
    stack_full <= 1'b0;
    cmd(6'h08);
    rd(OFF_STATUS, 32'h0, 32'h3);
    // idle with clock stopped, woken by external reset
    wr(OFF_WDT_CTRL, 32'h05);
    cmd(6'h30);
    chk(mode, MODE_IDLE0);
    chk(sysclk_run, 1'b0);
    wk_q.push_back(5'h10);
    cmd(6'h01);
    wait_q(5);
    // sleep with sub clock, watchdog overflow wakes
    @(posedge hclk) tick_on <= 1'b1;
    repeat (20) @(posedge hclk);
    rd(OFF_STATUS, 32'h8, 32'h8);
    cmd(6'h20);
    chk(mode, MODE_STOP_WITH_SUBCLOCK_MODE);
    wk_q.push_back(5'h08);
    wait_q(1500);
    @(posedge hclk) tick_on <= 1'b0;
    rd(OFF_STATUS, 32'h3, 32'h3);
    // overflow while running on system clock / 4
    wr(OFF_IRQ_EN, 32'h1);
    wr(OFF_CONFIG, 32'h05);
    cmd(6'h08);
    wk_q.push_back(5'h04);
    wait_q(1500);
    rd(OFF_STATUS, 32'h2, 32'h2);
    settle();
    chk(irq, 1'b1);
    wr(OFF_CONFIG, 32'h00);
    rd(OFF_STATUS, 32'h10, 32'h10);
    wr(OFF_WDT_CTRL, 32'h0a);
    rd(OFF_STATUS, 32'h0, 32'h10);
    wr(OFF_IRQ_EN, 32'h0);
    settle();
    chk(irq, 1'b0);
    wr(OFF_IRQ_EN, 32'h1);
    settle();
    chk(irq, 1'b1);
    wr(OFF_IRQ_CLR, 32'h1);
    settle();
    chk(irq, 1'b0);
    rd(OFF_IRQ_STAT, 32'h0, 32'h1);
    // deepest sleep: start-up count before running again
    cmd(6'h20);
    chk(mode, MODE_DEEP_STOP_MODE);
    wk_q.push_back(5'h02);
    @(posedge hclk) porta_in <= {r[7:2], 2'b10};
    @(posedge hclk) #1;
    chk(mode, MODE_START);
    wait_q(100);
    chk(mode, MODE_RUN);
    rd(OFF_STATUS, 32'h4, 32'h4);
    rd(OFF_STATUS, 32'h1, 32'h1);
    // two-clear option: repeats of one clear are ignored, alternation holds off the timeout
    wr(OFF_WDT_CTRL, 32'h05);
    wr(OFF_CONFIG, 32'h08);
    cmd(6'h04);
    wk_q.push_back(5'h04);
    for (i = 0; i < 8 && wk_q.size() > 0; i++) begin
      repeat (200) @(posedge hclk);
      cmd(6'h04);
    end
    wait_q(300);
    for (i = 0; i < 8; i++) begin
      repeat (200) @(posedge hclk);
      cmd(i[0] ? 6'h04 : 6'h02);
    end
    wr(OFF_WDT_CTRL, 32'h0a);
    // fast start from sleep with sub clock: low rc until the oscillator is ready
    wr(OFF_CONFIG, 32'h33);
    @(posedge hclk) porta_in <= {r[7:2], 2'b11};
    cmd(6'h20);
    chk(mode, MODE_STOP_WITH_SUBCLOCK_MODE);
    wk_q.push_back(5'h02);
    @(posedge hclk) porta_in <= {r[7:2], 2'b10};
    @(posedge hclk) #1;
    chk(mode, MODE_RUN);
    chk(sysclk_low, 1'b1);
    repeat (6) @(posedge hclk);
    #1;
    chk(sysclk_low, 1'b0);
    wait_q(5);
    stop_test();
  end
endmodule
`default_nettype wire

// ---- wdwk_top.sv ----
// watchdog timer and sleep/idle wake-up control with an AHB-Lite register slave
// assumes the core gives one-cycle instruction strobes and oscillator tick enables on hclk
//
// What this block does
// - wake on reset, Port A, interrupt, overflow
// - reset wake is full; overflow wake is watchdog
// - powerdown flag: clear at power-up/clear, set halt
// - timeout sets flag; wake resets only PC/SP
// - enabled Port A falling edge resumes after halt
// - disabled or stack-full interrupt resumes after halt
// - enabled interrupt, stack free: normal interrupt response
// - request pending before halt cannot wake
// - shared start-up counter, crystal after RC
// - deep stop wake waits for oscillator ready
// - fast start may run on low RC
// - peripherals follow system clock source switch
// - configured watchdog source and sub clock source
// - period select gives 256 to 32768
// - control bit 7 keeps clock in idle
// - disabled only by option and 1010
// - normal timeout resets device, sets flag
// - two-clear option needs alternating clear instructions
`timescale 1ns/1ps
`default_nettype none
module wdwk_top
  import wdwk_pkg::*;
#(
  parameter int NI      = 8,            // interrupt sources
  parameter int PA_W    = 8,            // Port A width
  parameter int HS_SST  = HS_SST_CYC,   // high-speed start-up cycles
  parameter int LXT_SST = LXT_SST_CYC   // crystal start-up ticks
) (
  input  wire logic                hclk,       // system clock
  input  wire logic                hresetn,    // power-up reset, active low
  input  wire logic                hsel,       // slave select
  input  wire logic [31:0]         haddr,      // byte address
  input  wire logic [1:0]          htrans,     // transfer type
  input  wire logic                hwrite,     // write not read
  input  wire logic [2:0]          hsize,      // transfer size
  input  wire logic [31:0]         hwdata,     // write data
  input  wire logic                hready,     // bus ready
  output var  logic [31:0]         hrdata,     // read data
  output var  logic                hreadyout,  // slave ready
  output var  logic                hresp,      // always okay
  input  wire wdwk_pkg::wdwk_cpu_t cpu,        // instruction strobes
  input  wire logic [NI-1:0]       intr_req,   // interrupt request flags
  input  wire logic [NI-1:0]       intr_en,    // interrupt enables
  input  wire logic                stack_full, // stack has no free level
  input  wire logic [PA_W-1:0]     porta_in,   // Port A pin levels
  input  wire logic                lxt_tick,   // low crystal tick enable
  input  wire logic                internal_low_rc_osc_tick,  // low RC tick enable
  output var  wdwk_pkg::wdwk_wake_t wake,      // wake and reset pulses
  output var  wdwk_pkg::wdwk_mode_t mode,      // operating mode
  output var  logic                sysclk_run, // system clock enabled
  output var  logic                sysclk_low, // system clock on low RC
  output var  logic                irq         // interrupt, level
);
  import wdwk_pkg::*;

  // ---------------- bus slave and software registers
  logic [7:0]       addr_reg, addr_next;
  logic             wr_pend_reg, wr_pend_next;
  logic             rd_pend_reg, rd_pend_next;
  logic [31:0]      hrdata_reg, hrdata_next;
  logic             hready_reg, hready_next;
  logic [7:0]       wdt_ctrl_reg, wdt_ctrl_next;
  logic [PA_W-1:0]  pa_wake_reg, pa_wake_next;
  logic [5:0]       cfg_reg, cfg_next;
  logic [IRQ_W-1:0] irq_en_reg, irq_en_next;
  logic [IRQ_W-1:0] irq_clr;

  // ---------------- watchdog state
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [1:0]       div_reg, div_next;
  wdwk_clr_t        last_clr_reg, last_clr_next;
  logic             pdf_reg, pdf_next;
  logic             to_reg, to_next;

  // ---------------- mode and wake state
  wdwk_mode_t       mode_reg, mode_next;
  logic [SST_W-1:0] sst_reg, sst_next;
  logic             hs_ready_reg, hs_ready_next;
  logic             lxt_ready_reg, lxt_ready_next;
  logic             on_internal_low_rc_osc_reg, on_internal_low_rc_osc_next;
  logic             run_reg, run_next;
  wdwk_wake_t       wake_reg, wake_next;
  wdwk_wake_t       pend_reg, pend_next;
  logic [PA_W-1:0]  pa_prev_reg, pa_prev_next;
  logic [NI-1:0]    armed_reg, armed_next;
  logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic             irq_reg, irq_next;

  // ---------------- shared combinational terms
  logic             wdt_active, asleep, halt_go, sys_tick, sys4_tick, sub_tick, src_tick, ovf, clr_ok;
  logic [2:0]       psel;
  logic [CNT_W-1:0] limit;

  assign psel       = wdt_ctrl_reg[PSEL_LSB +: 3];
  assign wdt_active = cfg_reg[CFG_WDT_EN] || (wdt_ctrl_reg[SOFT_LSB +: 4] != SOFT_DISABLE);
  assign asleep     = (mode_reg == MODE_IDLE0) || (mode_reg == MODE_IDLE_FULL_CLOCK_MODE) ||
                      (mode_reg == MODE_DEEP_STOP_MODE) || (mode_reg == MODE_STOP_WITH_SUBCLOCK_MODE);
  assign halt_go    = (mode_reg == MODE_RUN) && cpu.halt;
  assign sys_tick   = run_reg && (on_internal_low_rc_osc_reg ? internal_low_rc_osc_tick : 1'b1);
  assign sys4_tick  = sys_tick && (div_reg == 2'(SYS_DIV - 1));
  assign sub_tick   = cfg_reg[CFG_SUB_LXT] ? (lxt_tick && lxt_ready_reg) : internal_low_rc_osc_tick;
  assign src_tick   = (cfg_reg[CFG_SRC_SUB] ? sub_tick : sys4_tick) && (mode_reg != MODE_DEEP_STOP_MODE);
  assign limit      = CNT_W'((32'd1 << (WDT_BASE_LOG2 + 32'(psel))) - 32'd1);
  assign ovf        = wdt_active && src_tick && (cnt_reg == limit) && !halt_go;
  always_comb begin
    clr_ok = 1'b0;
    if (wdt_active && (mode_reg == MODE_RUN)) begin
      if (!cfg_reg[CFG_TWO_CLR]) begin
        clr_ok = cpu.clr;
      end else begin
        clr_ok = (cpu.clr1 && (last_clr_reg != CLR_FIRST)) ||
                 (cpu.clr2 && (last_clr_reg != CLR_SECOND));
      end
    end
  end

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      OFF_WDT_CTRL: rd_mux = 32'(wdt_ctrl_reg);
      OFF_PA_WAKE:  rd_mux = 32'(pa_wake_reg);
      OFF_STATUS:   rd_mux = 32'({mode_reg, on_internal_low_rc_osc_reg, wdt_active, lxt_ready_reg, hs_ready_reg, to_reg, pdf_reg});
      OFF_IRQ_STAT: rd_mux = 32'(irq_stat_reg);
      OFF_IRQ_EN:   rd_mux = 32'(irq_en_reg);
      OFF_WDT_CNT:  rd_mux = 32'(cnt_reg);
      OFF_CONFIG:   rd_mux = 32'(cfg_reg);
      default:      rd_mux = 32'h0000_0000;
    endcase
  endfunction

  // bus: writes complete with no wait, reads take one wait state
  always_comb begin
    addr_next     = addr_reg;
    wr_pend_next  = 1'b0;
    rd_pend_next  = 1'b0;
    hrdata_next   = hrdata_reg;
    hready_next   = 1'b1;
    wdt_ctrl_next = wdt_ctrl_reg;
    pa_wake_next  = pa_wake_reg;
    cfg_next      = cfg_reg;
    irq_en_next   = irq_en_reg;
    irq_clr       = '0;
    if (wr_pend_reg) begin
      case (addr_reg)
        OFF_WDT_CTRL: wdt_ctrl_next = hwdata[7:0];
        OFF_PA_WAKE:  pa_wake_next  = hwdata[PA_W-1:0];
        OFF_IRQ_CLR:  irq_clr       = hwdata[IRQ_W-1:0];
        OFF_IRQ_EN:   irq_en_next   = hwdata[IRQ_W-1:0];
        OFF_CONFIG:   cfg_next      = hwdata[5:0];
        default:      irq_clr       = '0;
      endcase
    end
    if (rd_pend_reg) begin
      hrdata_next = rd_mux(addr_reg);
    end else if (hsel && htrans[1] && hready && (hsize == HSIZE_WORD)) begin
      addr_next    = haddr[7:0];
      wr_pend_next = hwrite;
      rd_pend_next = !hwrite;
      hready_next  = hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg     <= '0;
      wr_pend_reg  <= 1'b0;
      rd_pend_reg  <= 1'b0;
      hrdata_reg   <= '0;
      hready_reg   <= 1'b1;
      wdt_ctrl_reg <= WDT_CTRL_RST;
      pa_wake_reg  <= PA_WAKE_RST;
      cfg_reg      <= CONFIG_RST;
      irq_en_reg   <= '0;
    end else begin
      addr_reg     <= addr_next;
      wr_pend_reg  <= wr_pend_next;
      rd_pend_reg  <= rd_pend_next;
      hrdata_reg   <= hrdata_next;
      hready_reg   <= hready_next;
      wdt_ctrl_reg <= wdt_ctrl_next;
      pa_wake_reg  <= pa_wake_next;
      cfg_reg      <= cfg_next;
      irq_en_reg   <= irq_en_next;
    end
  end

  // watchdog counter, clear instructions and the two status flags
  always_comb begin
    cnt_next      = cnt_reg;
    div_next      = sys_tick ? div_reg + 2'd1 : div_reg;
    last_clr_next = last_clr_reg;
    pdf_next      = pdf_reg;
    to_next       = to_reg;
    // halt marks power-down even with the watchdog switched off
    if (halt_go) begin
      cnt_next = '0;
      pdf_next = 1'b1;
      to_next  = 1'b0;
    end else if (!wdt_active) begin
      cnt_next = '0;
    end else if (ovf) begin
      cnt_next = '0;
      to_next  = 1'b1;
    end else if (clr_ok) begin
      cnt_next = '0;
      pdf_next = 1'b0;
      to_next  = 1'b0;
    end else if (src_tick) begin
      cnt_next = cnt_reg + CNT_W'(1);
    end
    if (clr_ok && cfg_reg[CFG_TWO_CLR]) begin
      last_clr_next = cpu.clr1 ? CLR_FIRST : CLR_SECOND;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg      <= '0;
      div_reg      <= '0;
      last_clr_reg <= CLR_NONE;
      pdf_reg      <= 1'b0;
      to_reg       <= 1'b0;
    end else begin
      cnt_reg      <= cnt_next;
      div_reg      <= div_next;
      last_clr_reg <= last_clr_next;
      pdf_reg      <= pdf_next;
      to_reg       <= to_next;
    end
  end

  // mode sequencing, oscillator start-up and wake decisions
  logic [PA_W-1:0] pa_fall;
  logic [NI-1:0]   int_new;
  logic            hs_count, lxt_count;
  wdwk_wake_t      act;
  assign pa_fall   = pa_prev_reg & ~porta_in & pa_wake_reg;
  assign int_new   = intr_req & armed_reg;
  assign hs_count  = !hs_ready_reg && (mode_reg != MODE_DEEP_STOP_MODE) && (mode_reg != MODE_STOP_WITH_SUBCLOCK_MODE);
  assign lxt_count = hs_ready_reg && !lxt_ready_reg && cfg_reg[CFG_SUB_LXT] && (mode_reg != MODE_DEEP_STOP_MODE);

  always_comb begin
    mode_next      = mode_reg;
    sst_next       = sst_reg;
    hs_ready_next  = hs_ready_reg;
    lxt_ready_next = lxt_ready_reg;
    on_internal_low_rc_osc_next   = on_internal_low_rc_osc_reg;
    wake_next      = '0;
    pend_next      = pend_reg;
    pa_prev_next   = porta_in;
    armed_next     = armed_reg;
    act            = '0;
    if (hs_count) begin
      if (sst_reg == SST_W'(HS_SST - 1)) begin
        sst_next      = '0;
        hs_ready_next = 1'b1;
        on_internal_low_rc_osc_next  = 1'b0;
      end else begin
        sst_next = sst_reg + SST_W'(1);
      end
    end else if (lxt_count && lxt_tick) begin
      if (sst_reg == SST_W'(LXT_SST - 1)) begin
        sst_next       = '0;
        lxt_ready_next = 1'b1;
      end else begin
        sst_next = sst_reg + SST_W'(1);
      end
    end
    if (cpu.ext_rst) begin
      act.full_reset = 1'b1;
    end else if (ovf) begin
      act.pcsp_reset = asleep;
      act.sys_reset  = !asleep;
    end else if (|int_new) begin
      act.int_take = |(int_new & intr_en) && !stack_full;
      act.resume   = !act.int_take;
    end else if (|pa_fall) begin
      act.resume = 1'b1;
    end
    case (mode_reg)
      MODE_RUN: begin
        wake_next.full_reset = act.full_reset;
        wake_next.sys_reset  = act.sys_reset;
        if (cpu.halt) begin
          armed_next = ~intr_req;
          if (cpu.idle_en) begin
            mode_next = wdt_ctrl_reg[IDLE_KEEP_BIT] ? MODE_IDLE_FULL_CLOCK_MODE : MODE_IDLE0;
          end else begin
            mode_next     = wdt_active ? MODE_STOP_WITH_SUBCLOCK_MODE : MODE_DEEP_STOP_MODE;
            sst_next      = '0;
            hs_ready_next = 1'b0;
            on_internal_low_rc_osc_next  = 1'b0;
            if (!wdt_active) begin
              lxt_ready_next = 1'b0;
            end
          end
        end
      end
      MODE_IDLE0, MODE_IDLE_FULL_CLOCK_MODE: begin
        if (|act) begin
          mode_next = MODE_RUN;
          wake_next = act;
        end
      end
      MODE_DEEP_STOP_MODE, MODE_STOP_WITH_SUBCLOCK_MODE: begin
        if (|act) begin
          pend_next = act;
          if ((mode_reg == MODE_STOP_WITH_SUBCLOCK_MODE) && cfg_reg[CFG_FAST_ST] && cfg_reg[CFG_SYS_HXT]) begin
            mode_next    = MODE_RUN;
            on_internal_low_rc_osc_next = 1'b1;
            wake_next    = act;
          end else begin
            mode_next = MODE_START;
          end
        end
      end
      MODE_START: begin
        if (hs_ready_reg) begin
          mode_next = MODE_RUN;
          wake_next = pend_reg;
          pend_next = '0;
        end
      end
      default: mode_next = MODE_START;
    endcase
  end

  // interrupt status: a set in the clearing cycle wins
  logic [IRQ_W-1:0] irq_set;
  assign irq_set = {hs_count && hs_ready_next, wake_next.resume | wake_next.int_take |
                    wake_next.pcsp_reset | wake_next.full_reset, ovf};
  always_comb begin
    irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
    irq_next      = |(irq_stat_next & irq_en_next);
    run_next      = (mode_next == MODE_RUN) || (mode_next == MODE_IDLE_FULL_CLOCK_MODE);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg      <= MODE_START;
      sst_reg       <= '0;
      hs_ready_reg  <= 1'b0;
      lxt_ready_reg <= 1'b0;
      on_internal_low_rc_osc_reg   <= 1'b0;
      run_reg       <= 1'b0;
      wake_reg      <= '0;
      pend_reg      <= '0;
      pa_prev_reg   <= PA_IDLE_LVL;
      armed_reg     <= '0;
      irq_stat_reg  <= '0;
      irq_reg       <= 1'b0;
    end else begin
      mode_reg      <= mode_next;
      sst_reg       <= sst_next;
      hs_ready_reg  <= hs_ready_next;
      lxt_ready_reg <= lxt_ready_next;
      on_internal_low_rc_osc_reg   <= on_internal_low_rc_osc_next;
      run_reg       <= run_next;
      wake_reg      <= wake_next;
      pend_reg      <= pend_next;
      pa_prev_reg   <= pa_prev_next;
      armed_reg     <= armed_next;
      irq_stat_reg  <= irq_stat_next;
      irq_reg       <= irq_next;
    end
  end

  assign hrdata     = hrdata_reg;
  assign hreadyout  = hready_reg;
  assign hresp      = HRESP_OKAY;
  assign wake       = wake_reg;
  assign mode       = mode_reg;
  assign sysclk_run = run_reg;
  assign sysclk_low = on_internal_low_rc_osc_reg;
  assign irq        = irq_reg;

  // ---------------- checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_deep_wake;
    (mode_reg == MODE_DEEP_STOP_MODE) ##1 (mode_reg == MODE_START);
  endsequence
  sequence s_idle_pa_wake;
    (mode_reg == MODE_IDLE_FULL_CLOCK_MODE) && (|pa_fall) && !cpu.ext_rst && !ovf && !(|int_new);
  endsequence

  AST_HALT_FLAGS: assert property (halt_go |=> pdf_reg && !to_reg && cnt_reg == '0)
    else $error("halt did not set powerdown flag");
  AST_TIMEOUT_FLAG: assert property (ovf |=> to_reg ##0 irq_stat_reg[IRQ_TIMEOUT])
    else $error("timeout flag not set on overflow");
  AST_NORMAL_RESET: assert property ((mode_reg == MODE_RUN) && ovf && !cpu.ext_rst |=> wake_reg.sys_reset)
    else $error("normal timeout gave no device reset");
  AST_SOFT_DISABLE: assert property (!cfg_reg[CFG_WDT_EN] && wdt_ctrl_reg[3:0] == 4'ha |=> cnt_reg == '0)
    else $error("disabled watchdog kept counting");
  AST_PERIOD_CAP: assert property (cnt_reg <= CNT_W'((32'd256 << psel) - 32'd1))
    else $error("watchdog count beyond selected period");
  AST_DEEP_READY: assert property ((wake_reg.resume || wake_reg.int_take) && !on_internal_low_rc_osc_reg |-> hs_ready_reg)
    else $error("execution resumed before oscillator ready");
  AST_DEEP_START: assert property (s_deep_wake |-> ##[1:20] (mode_reg == MODE_RUN))
    else $error("deep stop wake did not finish start-up");
  AST_ARMING: assert property (halt_go |=> armed_reg == ~$past(intr_req))
    else $error("pending request not excluded from wake");
  AST_PORTA_WAKE: assert property (s_idle_pa_wake |=> (mode_reg == MODE_RUN) && wake_reg.resume)
    else $error("Port A edge did not resume from idle");
  AST_CLR_REPEAT: assert property (cfg_reg[CFG_TWO_CLR] && cpu.clr1 && !cpu.clr2 &&
                                   last_clr_reg == CLR_FIRST && wdt_active && (mode_reg == MODE_RUN) &&
                                   !halt_go && !ovf && cnt_reg > CNT_W'(1) |=> cnt_reg != '0)
    else $error("repeated first clear cleared the watchdog");
  AST_LXT_ORDER: assert property ($rose(lxt_ready_reg) |-> hs_ready_reg)
    else $error("crystal start-up finished before RC");
  AST_IRQ_LEVEL: assert property (irq_reg == |(irq_stat_reg & irq_en_reg))
    else $error("interrupt line disagrees with status");
endmodule
`default_nettype wire
